// ---- bench/aif_event_flags_test.sv ----
// self-checking bench for the interrupt flag register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); err_total++; end end
module aif_event_flags_test;
	import aif_pkg::*;
	logic ref_clk_in;
	logic rst_n_in;
	logic [6:0] reg_addr_in;
	logic reg_rd_in;
	logic reg_wr_in;
	logic [7:0] reg_wdata_in;
	logic [7:0] reg_rdata_out;
	logic [7:0] cond;
	int err_total = 0;
	int checks_done = 0;
	aif_event_flags uut (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in),
		.reg_rd_in(reg_rd_in),
		.reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out),
		.short_left_in(cond[AIF_C_SHORT_L]),
		.short_right_in(cond[AIF_C_SHORT_R]),
		.button_in(cond[AIF_C_BUTTON]),
		.headset_in(cond[AIF_C_HEADSET]),
		.drc_power_left_in(cond[AIF_C_DRC_L]),
		.drc_power_right_in(cond[AIF_C_DRC_R]),
		.agc_noise_in(cond[AIF_C_AGC]),
		.dc_meas_ready_in(cond[AIF_C_DC])
	);
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	// one-cycle read strobe, data is settled one edge later
	task automatic rd(input logic [6:0] a, input logic [7:0] ex, input string nm);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge ref_clk_in);
		reg_rd_in = 1'b0;
		`CHK(nm, ex, reg_rdata_out)
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
	endtask
	task automatic sc_reset_values;
		rd(AIF_OFS_DAC_LATCHED, 8'h00, "dac latched reset");
		rd(AIF_OFS_ADC_LATCHED, 8'h00, "adc latched reset");
		rd(AIF_OFS_DAC_LIVE, 8'h00, "dac live reset");
		rd(AIF_OFS_ADC_LIVE, 8'h00, "adc live reset");
	endtask
	// each dac condition: live follows, sticky latches once, read clears it
	task automatic sc_dac_bits;
		logic [7:0] e;
		for (int i = 7; i >= 2; i--) begin
			e = 8'h00;
			e[i] = 1'b1;
			cond[i] = 1'b1;
			idle(4);
			rd(AIF_OFS_DAC_LIVE, e, "dac live set");
			rd(AIF_OFS_DAC_LIVE, e, "dac live kept");
			rd(AIF_OFS_DAC_LATCHED, e, "dac sticky set");
			rd(AIF_OFS_DAC_LATCHED, 8'h00, "dac sticky cleared");
			cond[i] = 1'b0;
			idle(4);
			rd(AIF_OFS_DAC_LIVE, 8'h00, "dac live dropped");
			e = (i == 4) ? 8'h10 : 8'h00;
			rd(AIF_OFS_DAC_LATCHED, e, "dac sticky on fall");
			rd(AIF_OFS_DAC_LATCHED, 8'h00, "dac sticky idle");
		end
	endtask
	// a fresh rising edge after a read sets the flag again
	task automatic sc_retrigger;
		cond[AIF_C_SHORT_L] = 1'b1;
		idle(4);
		rd(AIF_OFS_DAC_LATCHED, 8'h80, "short first");
		cond[AIF_C_SHORT_L] = 1'b0;
		idle(4);
		rd(AIF_OFS_DAC_LATCHED, 8'h00, "short gone");
		cond[AIF_C_SHORT_L] = 1'b1;
		idle(4);
		rd(AIF_OFS_DAC_LATCHED, 8'h80, "short again");
		cond[AIF_C_SHORT_L] = 1'b0;
		idle(4);
		rd(AIF_OFS_DAC_LATCHED, 8'h00, "short cleared");
	endtask
	task automatic sc_adc_bits;
		cond[AIF_C_AGC] = 1'b1;
		idle(4);
		rd(AIF_OFS_ADC_LIVE, 8'h40, "agc live");
		rd(AIF_OFS_ADC_LATCHED, 8'h40, "agc sticky");
		rd(AIF_OFS_ADC_LATCHED, 8'h00, "agc cleared");
		rd(AIF_OFS_ADC_LIVE, 8'h40, "agc live kept");
		cond[AIF_C_AGC] = 1'b0;
		cond[AIF_C_DC] = 1'b1;
		idle(4);
		rd(AIF_OFS_ADC_LIVE, 8'h04, "dc live");
		rd(AIF_OFS_ADC_LATCHED, 8'h04, "dc latched");
		rd(AIF_OFS_ADC_LATCHED, 8'h04, "dc not sticky");
		cond[AIF_C_DC] = 1'b0;
		idle(4);
		rd(AIF_OFS_ADC_LATCHED, 8'h00, "dc gone");
	endtask
	// writes to flag bits leave latched and live state alone; writable adc reserved bits get zeros
	task automatic sc_writes;
		cond[AIF_C_SHORT_L] = 1'b1;
		cond[AIF_C_AGC] = 1'b1;
		idle(4);
		wr(7'h30, 8'hff);
		wr(AIF_OFS_DAC_LIVE, 8'h7f);
		wr(AIF_OFS_ADC_LATCHED, 8'h04);
		wr(AIF_OFS_ADC_LIVE, 8'h04);
		rd(AIF_OFS_DAC_LATCHED, 8'h80, "dac latched write");
		rd(AIF_OFS_DAC_LIVE, 8'h80, "dac live write");
		rd(AIF_OFS_ADC_LATCHED, 8'h40, "adc latched write");
		rd(AIF_OFS_ADC_LIVE, 8'h40, "adc live write");
		rd(7'h30, 8'h00, "unmapped read");
		wr(AIF_OFS_ADC_LATCHED, 8'h00);
		wr(AIF_OFS_ADC_LIVE, 8'h00);
		rd(AIF_OFS_ADC_LATCHED, 8'h00, "adc latched zeroed");
		rd(AIF_OFS_ADC_LIVE, 8'h40, "adc live zeroed");
		cond = 8'h00;
		idle(4);
	endtask
	initial begin
		rst_n_in = 1'b0;
		reg_addr_in = 7'h00;
		reg_rd_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_wdata_in = 8'h00;
		cond = 8'h00;
		repeat (4) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_n_in = 1'b1;
		idle(2);
		sc_reset_values();
		sc_dac_bits();
		sc_retrigger();
		sc_adc_bits();
		sc_writes();
		close_out();
	end
	// cut a hang short
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire

// ---- rtl/aif_event_flags.sv ----
// interrupt flag registers: latched and live status of codec events
// Summary of operation
// RULE1: reading a latched register clears its sticky bits
// RULE2: cleared flag stays zero until new trigger
// RULE3: dac latched D7 sets on left short
// RULE4: dac latched D6 sets on right short
// RULE5: dac latched D5 sets on button press
// RULE6: dac latched D4 sets on headset plug change
// RULE7: dac latched D3/D2 set on compressor power
// RULE8: adc latched D6 sets on gain-control noise
// RULE9: adc D2 shows dc measurement availability
// RULE10: live dac D7/D6 show shorts, not cleared
// RULE11: live D5 button, D4 headset inserted
// RULE12: live D3/D2 show compressor power above threshold
// RULE13: live adc D6 shows noise below threshold
// RULE14: host writes zeros to reserved bits only
// RULE15: sticky flags set on live condition rising
// RULE16: read-only bits ignore writes, reserved read zero; the writable adc reserved bits read back the value last written
`timescale 1ns/1ps
`default_nettype none
module aif_event_flags
	import aif_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic short_left_in,
	input wire logic short_right_in,
	input wire logic button_in,
	input wire logic headset_in,
	input wire logic drc_power_left_in,
	input wire logic drc_power_right_in,
	input wire logic agc_noise_in,
	input wire logic dc_meas_ready_in
);
	logic [AIF_NUM_COND-1:0] cond_meta;
	logic [AIF_NUM_COND-1:0] live;
	logic [AIF_NUM_COND-1:0] live_prev;
	logic [2:0] adc_latched_rsv;
	logic [3:0] adc_live_rsv;
	wire logic [AIF_NUM_COND-1:0] cond_raw;
	wire logic [AIF_NUM_COND-1:0] cond_rise;
	wire logic [AIF_NUM_STICKY-1:0] sticky;
	wire logic [AIF_NUM_STICKY-1:0] evt;
	wire logic hit_dac_latched;
	wire logic hit_adc_latched;
	wire logic hit_dac_live;
	wire logic hit_adc_live;
	wire logic rd_dac_latched;
	wire logic rd_adc_latched;
	wire logic [7:0] val_dac_latched;
	wire logic [7:0] val_adc_latched;
	wire logic [7:0] val_dac_live;
	wire logic [7:0] val_adc_live;
	wire logic [7:0] next_rdata;
	wire logic [2:0] next_adc_latched_rsv;
	wire logic [3:0] next_adc_live_rsv;

	aif_flag_if #(.W(AIF_NUM_STICKY)) fl ();

	aif_sticky_bank #(.W(AIF_NUM_STICKY)) u_bank (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.fl(fl.bank)
	);

	assign cond_raw = {short_left_in, short_right_in, button_in, headset_in,
		drc_power_left_in, drc_power_right_in, agc_noise_in, dc_meas_ready_in};

	// condition pins come from analog detectors: two flops before use
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cond_meta <= AIF_RST_COND;
			live <= AIF_RST_COND;
			live_prev <= AIF_RST_COND;
		end else begin
			cond_meta <= cond_raw;
			live <= cond_meta;
			live_prev <= live;
		end
	end

	// sticky events follow the live condition edges; a held level never re-arms
	assign cond_rise = live & ~live_prev; // RULE15 RULE2
	assign evt[AIF_S_SHORT_L] = cond_rise[AIF_C_SHORT_L]; // RULE3
	assign evt[AIF_S_SHORT_R] = cond_rise[AIF_C_SHORT_R]; // RULE4
	assign evt[AIF_S_BUTTON] = cond_rise[AIF_C_BUTTON]; // RULE5
	// plug change: insertion or removal
	assign evt[AIF_S_HEADSET] = live[AIF_C_HEADSET] ^ live_prev[AIF_C_HEADSET]; // RULE6
	assign evt[AIF_S_DRC_L] = cond_rise[AIF_C_DRC_L]; // RULE7
	assign evt[AIF_S_DRC_R] = cond_rise[AIF_C_DRC_R]; // RULE7
	assign evt[AIF_S_AGC] = cond_rise[AIF_C_AGC]; // RULE8

	assign hit_dac_latched = (reg_addr_in == AIF_OFS_DAC_LATCHED);
	assign hit_adc_latched = (reg_addr_in == AIF_OFS_ADC_LATCHED);
	assign hit_dac_live = (reg_addr_in == AIF_OFS_DAC_LIVE);
	assign hit_adc_live = (reg_addr_in == AIF_OFS_ADC_LIVE);
	assign rd_dac_latched = reg_rd_in && hit_dac_latched;
	assign rd_adc_latched = reg_rd_in && hit_adc_latched;

	assign fl.set_evt = evt;
	// a read clears exactly the sticky bits of the register read
	assign fl.clr = {{6{rd_dac_latched}}, rd_adc_latched}; // RULE1
	assign sticky = fl.flags;

	// read-only reserved bits read as zero
	assign val_dac_latched = {sticky[AIF_S_SHORT_L:AIF_S_DRC_R], 2'b00}; // RULE16
	assign val_adc_latched = {adc_latched_rsv[2], sticky[AIF_S_AGC], 3'b000,
		live[AIF_C_DC], adc_latched_rsv[1:0]}; // RULE9
	assign val_dac_live = {live[AIF_C_SHORT_L:AIF_C_DRC_R], 2'b00}; // RULE10 RULE11 RULE12
	assign val_adc_live = {adc_live_rsv[3], live[AIF_C_AGC], adc_live_rsv[2], 2'b00,
		live[AIF_C_DC], adc_live_rsv[1:0]}; // RULE13 RULE9

	assign next_rdata = hit_dac_latched ? val_dac_latched :
		hit_adc_latched ? val_adc_latched :
		hit_dac_live ? val_dac_live :
		hit_adc_live ? val_adc_live : 8'h00;

	// only the writable reserved bits store; flag bits ignore writes
	assign next_adc_latched_rsv = (reg_wr_in && hit_adc_latched) ?
		{reg_wdata_in[7], reg_wdata_in[1:0]} : adc_latched_rsv; // RULE16
	assign next_adc_live_rsv = (reg_wr_in && hit_adc_live) ?
		{reg_wdata_in[7], reg_wdata_in[5], reg_wdata_in[1:0]} : adc_live_rsv; // RULE16

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= AIF_RST_RDATA;
			adc_latched_rsv <= AIF_RST_ADC_LATCHED_RSV;
			adc_live_rsv <= AIF_RST_ADC_LIVE_RSV;
		end else begin
			if (reg_rd_in) begin
				reg_rdata_out <= next_rdata;
			end
			adc_latched_rsv <= next_adc_latched_rsv;
			adc_live_rsv <= next_adc_live_rsv;
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_read_clears_dac: assert property ( // RULE1
		(rd_dac_latched && (evt[6:1] == '0)) |=> (sticky[6:1] == '0))
		else $error("dac sticky flags not cleared by read");

	chk_read_clears_adc: assert property ( // RULE1
		(rd_adc_latched && !evt[AIF_S_AGC]) |=> !sticky[AIF_S_AGC])
		else $error("adc sticky flag not cleared by read");

	chk_no_spurious_set: assert property ( // RULE2
		1'b1 |=> ((sticky & ~$past(sticky) & ~$past(evt)) == '0))
		else $error("sticky flag set without trigger");

	chk_short_left_latch: assert property ( // RULE3
		$rose(live[AIF_C_SHORT_L]) |=> sticky[AIF_S_SHORT_L])
		else $error("left short not latched");

	chk_short_right_latch: assert property ( // RULE4
		$rose(live[AIF_C_SHORT_R]) |=> sticky[AIF_S_SHORT_R])
		else $error("right short not latched");

	chk_button_latch: assert property ( // RULE5
		$rose(live[AIF_C_BUTTON]) |=> sticky[AIF_S_BUTTON])
		else $error("button press not latched");

	chk_headset_both_edges: assert property ( // RULE6
		$changed(live[AIF_C_HEADSET]) |=> sticky[AIF_S_HEADSET])
		else $error("headset change not latched");

	chk_drc_latch: assert property ( // RULE7
		$rose(live[AIF_C_DRC_L]) |=> sticky[AIF_S_DRC_L])
		else $error("left compressor power not latched");

	chk_drc_right_latch: assert property ( // RULE7
		$rose(live[AIF_C_DRC_R]) |=> sticky[AIF_S_DRC_R])
		else $error("right compressor power not latched");

	chk_agc_latch: assert property ( // RULE8
		$rose(live[AIF_C_AGC]) |=> sticky[AIF_S_AGC])
		else $error("noise flag not latched");

	chk_dac_read_data: assert property ( // RULE1
		rd_dac_latched |=> (reg_rdata_out == {$past(sticky[6:1]), 2'b00}))
		else $error("dac latched read data wrong");

	chk_dc_available: assert property ( // RULE9
		rd_adc_latched |=> (reg_rdata_out[AIF_B_DC] == $past(live[AIF_C_DC])))
		else $error("dc measurement bit wrong");

	chk_live_dac_read: assert property ( // RULE10
		(reg_rd_in && hit_dac_live) |=>
		(reg_rdata_out == {$past(live[7:2]), 2'b00}) && (($past(sticky) & ~sticky) == '0))
		else $error("live dac read wrong");

	chk_live_adc_read: assert property ( // RULE13
		(reg_rd_in && hit_adc_live) |=>
		(reg_rdata_out[AIF_B_AGC] == $past(live[AIF_C_AGC])))
		else $error("live adc noise bit wrong");

	chk_ro_write_ignored: assert property ( // RULE16
		(reg_wr_in && !reg_rd_in && (evt == '0)) |=> $stable(sticky))
		else $error("write changed flag state");

	cov_read_clear: cover property (rd_dac_latched && (sticky != '0));
	cov_set_with_clear: cover property (rd_dac_latched && (evt[6:1] != '0));
	cov_headset_removal: cover property ($fell(live[AIF_C_HEADSET]));
	cov_agc_read: cover property (rd_adc_latched && sticky[AIF_S_AGC]);
endmodule
`default_nettype wire

// ---- rtl/aif_flag_if.sv ----
// carrier between the register logic and the sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface aif_flag_if #(parameter int W = 7);
	logic [W-1:0] set_evt;
	logic [W-1:0] clr;
	logic [W-1:0] flags;
	modport bank(input set_evt, input clr, output flags);
	modport user(output set_evt, output clr, input flags);
endinterface
`default_nettype wire

// ---- rtl/aif_pkg.sv ----
// constants shared by the interrupt flag bank modules
`default_nettype none
package aif_pkg;
	// register offsets on the control port
	localparam logic [6:0] AIF_OFS_DAC_LATCHED = 7'h2c;
	localparam logic [6:0] AIF_OFS_ADC_LATCHED = 7'h2d;
	localparam logic [6:0] AIF_OFS_DAC_LIVE = 7'h2e;
	localparam logic [6:0] AIF_OFS_ADC_LIVE = 7'h2f;
	// number of condition inputs and sticky flags
	localparam int AIF_NUM_COND = 8;
	localparam int AIF_NUM_STICKY = 7;
	// condition vector positions
	localparam int AIF_C_SHORT_L = 7;
	localparam int AIF_C_SHORT_R = 6;
	localparam int AIF_C_BUTTON = 5;
	localparam int AIF_C_HEADSET = 4;
	localparam int AIF_C_DRC_L = 3;
	localparam int AIF_C_DRC_R = 2;
	localparam int AIF_C_AGC = 1;
	localparam int AIF_C_DC = 0;
	// sticky vector positions
	localparam int AIF_S_SHORT_L = 6;
	localparam int AIF_S_SHORT_R = 5;
	localparam int AIF_S_BUTTON = 4;
	localparam int AIF_S_HEADSET = 3;
	localparam int AIF_S_DRC_L = 2;
	localparam int AIF_S_DRC_R = 1;
	localparam int AIF_S_AGC = 0;
	// field positions inside the registers
	localparam int AIF_B_DC = 2;
	localparam int AIF_B_AGC = 6;
	// reset values
	localparam logic [7:0] AIF_RST_COND = 8'h00;
	localparam logic [6:0] AIF_RST_STICKY = 7'h00;
	localparam logic [7:0] AIF_RST_RDATA = 8'h00;
	localparam logic [2:0] AIF_RST_ADC_LATCHED_RSV = 3'h0;
	localparam logic [3:0] AIF_RST_ADC_LIVE_RSV = 4'h0;
endpackage
`default_nettype wire

// ---- rtl/aif_sticky_bank.sv ----
// bank of sticky flags, set by events and cleared by reads
`timescale 1ns/1ps
`default_nettype none
module aif_sticky_bank
	import aif_pkg::*;
#(
	parameter int W = AIF_NUM_STICKY
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	aif_flag_if.bank fl
);
	logic [W-1:0] flags;
	wire logic [W-1:0] next_flags;

	if (W < 1) begin : g_bad_width
		$error("sticky bank needs at least one flag");
	end

	// a set in the clearing cycle wins so that no event is lost
	assign next_flags = (flags & ~fl.clr) | fl.set_evt; // RULE1
	assign fl.flags = flags;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags <= W'(AIF_RST_STICKY);
		end else begin
			flags <= next_flags;
		end
	end

	chk_set_wins_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RULE1
		(fl.set_evt != '0) |=> ((flags & $past(fl.set_evt)) == $past(fl.set_evt)))
		else $error("event lost while clearing");
endmodule
`default_nettype wire
